// ---- shared/cpu_exec_pkg.sv ----
package cpu_exec_pkg;

	// ----------------------------------------------------------------
	// Opcode classes handed in by the fetch stage
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_PRODUCT = 4'h1,
		OP_QUOTIENT = 4'h2,
		OP_AND = 4'h3,
		OP_OR = 4'h4,
		OP_XOR = 4'h5,
		OP_LONG_JUMP = 4'h6,
		OP_BLOCK_JUMP = 4'h7,
		OP_REL_JUMP = 4'h8,
		OP_BR_ZERO = 4'h9,
		OP_BR_NONZERO = 4'ha,
		OP_BR_CARRY = 4'hb,
		OP_BR_NO_CARRY = 4'hc,
		OP_BR_BIT = 4'hd,
		OP_BR_BIT_CLEAR = 4'he,
		OP_BR_BIT_AND_CLR = 4'hf
	} exec_op_e;

	// Call and return class, separate so the op class fits four bits and this one three
	typedef enum logic [2:0] {
		FL_NONE = 3'h0,
		FL_LONG_CALL = 3'h1,
		FL_BLOCK_CALL = 3'h2,
		FL_CALL_EXIT = 3'h3,
		FL_HANDLER_EXIT = 3'h4
	} flow_op_e;

	// Second operand source of the bitwise operations
	typedef enum logic [1:0] {
		SRC_ACC = 2'h0,
		SRC_IMM = 2'h1,
		SRC_DIRECT = 2'h2
	} src_sel_e;

	// Sequencer states, Gray coded in declaration order
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH_HI = 3'b001,
		ST_POP_LO = 3'b011,
		ST_DIV = 3'b010,
		ST_DONE = 3'b110
	} seq_state_e;

	// One decoded instruction
	typedef struct packed {
		exec_op_e op;
		flow_op_e flow;
		src_sel_e src;
		logic dst_direct;
		logic [7:0] opcode;
		logic [7:0] byte2;
		logic [7:0] byte3;
	} instr_s;

	// CPU state visible to this block
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] breg;
		logic [7:0] sp;
		logic [15:0] pc;
		logic carry;
		logic signed_excess_flag;
	} cpu_state_s;

	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int BLOCK_LSB = 11;
	localparam int OPC_BLK_LSB = 5;
	localparam int LVL_W = 2;
	localparam logic [LVL_W-1:0] LVL_IDLE = 2'h0;
	localparam int DIV_STEPS = 8;
	localparam logic [3:0] DIV_CNT_RESET = 4'h0;

endpackage : cpu_exec_pkg

// ---- design/div_unit.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Restoring unsigned divider, one quotient bit per cycle
// ----------------------------------------------------------------
module div_unit (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic [7:0] dividend_i,
	input wire logic [7:0] divisor_i,
	output logic busy_o,
	output logic [7:0] quot_o,
	output logic [7:0] rem_o
);
	import cpu_exec_pkg::*;

	logic [7:0] quot_r, quot_nxt;
	logic [8:0] rem_r, rem_nxt;
	logic [7:0] dvs_r, dvs_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [8:0] trial;

	// One shift-subtract step per cycle keeps the path short
	always_comb begin
		quot_nxt = quot_r;
		rem_nxt = rem_r;
		dvs_nxt = dvs_r;
		cnt_nxt = cnt_r;
		trial = {rem_r[7:0], quot_r[7]};
		if (start_i) begin
			quot_nxt = dividend_i;
			rem_nxt = 9'h000;
			dvs_nxt = divisor_i;
			cnt_nxt = 4'(DIV_STEPS);
		end else if (cnt_r != DIV_CNT_RESET) begin
			cnt_nxt = cnt_r - 4'h1;
			if (trial >= {1'b0, dvs_r}) begin
				rem_nxt = trial - {1'b0, dvs_r};
				quot_nxt = {quot_r[6:0], 1'b1};
			end else begin
				rem_nxt = trial;
				quot_nxt = {quot_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			quot_r <= BYTE_ZERO;
			rem_r <= 9'h000;
			dvs_r <= BYTE_ZERO;
			cnt_r <= DIV_CNT_RESET;
		end else begin
			quot_r <= quot_nxt;
			rem_r <= rem_nxt;
			dvs_r <= dvs_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign busy_o = (cnt_r != DIV_CNT_RESET);
	assign quot_o = quot_r;
	assign rem_o = rem_r[7:0];

endmodule : div_unit

// ---- design/cpu_muldiv_logic_branch_exec.sv ----
`timescale 1ns/100ps
// Behaviour
// (RL1) Multiply accumulator by second register; low byte to accumulator, high to second.
// (RL2) After multiply, excess flag set when upper product byte is nonzero.
// (RL3) Divide accumulator by second register; quotient, remainder; clear excess flag.
// (RL4) Zero divisor sets excess flag; results undefined.
// (RL5) AND, OR, XOR write the first operand and leave flags alone.
// (RL6) Bitwise destination may be direct byte, source accumulator or immediate.
// (RL7) Long jump takes sixteen-bit target from bytes two and three.
// (RL8) Block jump: opcode bits give target 10..8, byte two 7..0.
// (RL9) Relative jump adds signed displacement to incremented program counter.
// (RL10) Zero displacement continues at the following instruction.
// (RL11) Zero and carry branches are two bytes, relative target.
// (RL12) Bit branches are three bytes: bit select then relative offset.
// (RL13) Call pushes next address low byte first; stack pointer rises two.
// (RL14) Long and block calls encode targets like long and block jumps.
// (RL15) Return pops high then low byte; stack pointer falls two.
// (RL16) Interrupt forces long call to vector, saving only return address.
// (RL17) Active service refuses requests of same or lower priority.
// (RL18) Handler exit returns like call exit and restores prior acceptance.
// (RL19) Bit-and-clear clears the bit only when set and taken.
module cpu_muldiv_logic_branch_exec (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic instr_valid_i,
	input wire cpu_exec_pkg::instr_s instr_i,
	input wire logic [15:0] next_pc_i,
	input wire logic [7:0] direct_rd_i,
	input wire logic bit_rd_i,
	input wire logic [7:0] stack_rd_i,
	input wire logic irq_req_i,
	input wire logic irq_hi_i,
	input wire logic [15:0] irq_vector_i,
	output cpu_exec_pkg::cpu_state_s state_o,
	output logic done_o,
	output logic direct_we_o,
	output logic [7:0] direct_wdata_o,
	output logic bit_clr_o,
	output logic stack_we_o,
	output logic [7:0] stack_addr_o,
	output logic [7:0] stack_wdata_o,
	output logic irq_ack_o,
	output logic [1:0] irq_level_o
);
	import cpu_exec_pkg::*;

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	cpu_state_s st_r, st_nxt;
	seq_state_e seq_r, seq_nxt;
	logic done_r, done_nxt;
	logic dwe_r, dwe_nxt;
	logic [7:0] dwd_r, dwd_nxt;
	logic bclr_r, bclr_nxt;
	logic swe_r, swe_nxt;
	logic [7:0] sad_r, sad_nxt;
	logic [7:0] swd_r, swd_nxt;
	logic ack_r, ack_nxt;
	logic [LVL_W-1:0] lvl_r, lvl_nxt;
	logic [7:0] ret_hi_r, ret_hi_nxt;
	logic is_handler_r, is_handler_nxt;
	logic irq_hi_prev_r, irq_hi_prev_nxt;
	logic div_start;
	logic div_busy;
	logic [7:0] div_q;
	logic [7:0] div_rem;
	logic [15:0] prod;
	logic [15:0] rel_tgt;
	logic [15:0] blk_tgt;
	logic [7:0] src_val;
	logic [7:0] dst_val;
	logic [7:0] logic_res;
	logic take;
	logic irq_take;

	div_unit u_div (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.start_i(div_start),
		.dividend_i(st_r.acc),
		.divisor_i(st_r.breg),
		.busy_o(div_busy),
		.quot_o(div_q),
		.rem_o(div_rem)
	);

	// ----------------------------------------------------------------
	// Datapath helpers
	// ----------------------------------------------------------------
	// (RL1) unsigned product
	assign prod = st_r.acc * st_r.breg;
	// (RL9) sign-extended displacement, zero gives the next address (RL10)
	assign rel_tgt = next_pc_i +
		rel_ext(is_bit_op(instr_i.op) ? instr_i.byte3 : instr_i.byte2);
	// (RL8) block target keeps the incremented counter's upper bits
	assign blk_tgt = {next_pc_i[15:BLOCK_LSB], instr_i.opcode[7:OPC_BLK_LSB],
		instr_i.byte2};
	// (RL6) source is accumulator, immediate or direct byte; destination direct or accumulator
	assign src_val = (instr_i.src == SRC_IMM) ? instr_i.byte2 :
		(instr_i.src == SRC_DIRECT) ? direct_rd_i : st_r.acc;
	assign dst_val = instr_i.dst_direct ? direct_rd_i : st_r.acc;
	// (RL17) only a higher level than the running one is accepted
	assign irq_take = irq_req_i && (seq_r == ST_IDLE) && !instr_valid_i &&
		(lvl_r < (irq_hi_i ? 2'h2 : 2'h1));

	function automatic logic is_bit_op(input exec_op_e op);
		is_bit_op = (op == OP_BR_BIT) || (op == OP_BR_BIT_CLEAR) ||
			(op == OP_BR_BIT_AND_CLR);
	endfunction : is_bit_op

	function automatic logic [15:0] rel_ext(input logic [7:0] d);
		rel_ext = {{8{d[7]}}, d};
	endfunction : rel_ext

	// Bitwise result and branch condition
	always_comb begin
		logic_res = dst_val;
		take = 1'b0;
		unique case (instr_i.op)
			// (RL5) flags untouched by these three
			OP_AND: logic_res = dst_val & src_val;
			OP_OR: logic_res = dst_val | src_val;
			OP_XOR: logic_res = dst_val ^ src_val;
			OP_REL_JUMP: take = 1'b1;
			// (RL11) accumulator and carry tests
			OP_BR_ZERO: take = (st_r.acc == BYTE_ZERO);
			OP_BR_NONZERO: take = (st_r.acc != BYTE_ZERO);
			OP_BR_CARRY: take = st_r.carry;
			OP_BR_NO_CARRY: take = !st_r.carry;
			// (RL12) bit selected by byte two, offset in byte three
			OP_BR_BIT: take = bit_rd_i;
			OP_BR_BIT_CLEAR: take = !bit_rd_i;
			OP_BR_BIT_AND_CLR: take = bit_rd_i;
			default: take = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Stack traffic takes two cycles, one byte each, so one RAM port suffices
	always_comb begin
		st_nxt = st_r;
		seq_nxt = seq_r;
		done_nxt = 1'b0;
		dwe_nxt = 1'b0;
		dwd_nxt = dwd_r;
		bclr_nxt = 1'b0;
		swe_nxt = 1'b0;
		sad_nxt = sad_r;
		swd_nxt = swd_r;
		ack_nxt = 1'b0;
		lvl_nxt = lvl_r;
		ret_hi_nxt = ret_hi_r;
		is_handler_nxt = is_handler_r;
		div_start = 1'b0;
		unique case (seq_r)
			ST_IDLE: begin
				if (irq_take) begin
					// (RL16) forced long call; return address only, no status
					ack_nxt = 1'b1;
					lvl_nxt = irq_hi_i ? 2'h2 : 2'h1;
					is_handler_nxt = 1'b0;
					swe_nxt = 1'b1;
					sad_nxt = st_r.sp + 8'h01;
					swd_nxt = next_pc_i[7:0];
					ret_hi_nxt = next_pc_i[15:8];
					st_nxt.pc = irq_vector_i;
					seq_nxt = ST_PUSH_HI;
				end else if (instr_valid_i) begin
					st_nxt.pc = next_pc_i;
					if (instr_i.flow == FL_LONG_CALL || instr_i.flow == FL_BLOCK_CALL) begin
						// (RL13) low byte first into sp+1
						swe_nxt = 1'b1;
						sad_nxt = st_r.sp + 8'h01;
						swd_nxt = next_pc_i[7:0];
						ret_hi_nxt = next_pc_i[15:8];
						// (RL14) targets as for the jumps
						st_nxt.pc = (instr_i.flow == FL_LONG_CALL) ?
							{instr_i.byte2, instr_i.byte3} : blk_tgt;
						seq_nxt = ST_PUSH_HI;
					end else if (instr_i.flow == FL_CALL_EXIT ||
						instr_i.flow == FL_HANDLER_EXIT) begin
						// (RL15) high byte read from sp first
						sad_nxt = st_r.sp;
						is_handler_nxt = (instr_i.flow == FL_HANDLER_EXIT);
						seq_nxt = ST_POP_LO;
					end else begin
						done_nxt = 1'b1;
						unique case (instr_i.op)
							OP_PRODUCT: begin
								st_nxt.acc = prod[7:0];
								st_nxt.breg = prod[15:8];
								// (RL2) excess when upper byte nonzero
								st_nxt.signed_excess_flag = (prod[15:8] != BYTE_ZERO);
							end
							OP_QUOTIENT: begin
								done_nxt = 1'b0;
								div_start = 1'b1;
								seq_nxt = ST_DIV;
							end
							OP_AND, OP_OR, OP_XOR: begin
								if (instr_i.dst_direct) begin
									dwe_nxt = 1'b1;
									dwd_nxt = logic_res;
								end else begin
									st_nxt.acc = logic_res;
								end
							end
							// (RL7) full sixteen-bit target
							OP_LONG_JUMP: st_nxt.pc = {instr_i.byte2, instr_i.byte3};
							// (RL8) same 2K block
							OP_BLOCK_JUMP: st_nxt.pc = blk_tgt;
							default: begin
								if (take) begin
									st_nxt.pc = rel_tgt;
								end
								// (RL19) clear only when set and taken
								bclr_nxt = (instr_i.op == OP_BR_BIT_AND_CLR) && take;
							end
						endcase
					end
				end
			end
			ST_PUSH_HI: begin
				swe_nxt = 1'b1;
				sad_nxt = st_r.sp + 8'h02;
				swd_nxt = ret_hi_r;
				// (RL13) pointer up by two
				st_nxt.sp = st_r.sp + 8'h02;
				seq_nxt = ST_DONE;
			end
			ST_POP_LO: begin
				ret_hi_nxt = stack_rd_i;
				sad_nxt = st_r.sp - 8'h01;
				seq_nxt = ST_DONE;
				// (RL18) handler exit restores the prior level: 1 if a low service was nested, else idle
				if (is_handler_r && lvl_r != LVL_IDLE) begin
					lvl_nxt = (lvl_r == 2'h2 && irq_hi_prev_r) ? 2'h1 : LVL_IDLE;
				end
			end
			ST_DIV: begin
				if (!div_busy) begin
					// (RL4) zero divisor flags error, results left as produced
					// (RL3) otherwise quotient, remainder and clear flag
					st_nxt.acc = div_q;
					st_nxt.breg = div_rem;
					st_nxt.signed_excess_flag = (st_r.breg == BYTE_ZERO);
					done_nxt = 1'b1;
					seq_nxt = ST_IDLE;
				end
			end
			ST_DONE: begin
				if (sad_r == st_r.sp - 8'h01) begin
					// (RL15) low byte read, pointer down by two
					st_nxt.pc = {ret_hi_r, stack_rd_i};
					st_nxt.sp = st_r.sp - 8'h02;
				end
				done_nxt = 1'b1;
				seq_nxt = ST_IDLE;
			end
			default: seq_nxt = ST_IDLE;
		endcase
	end

	// Remembers a low-level service under a high one, so exits unwind in order
	always_comb begin
		irq_hi_prev_nxt = irq_hi_prev_r;
		if (seq_r == ST_IDLE && irq_take) begin
			irq_hi_prev_nxt = (lvl_r == 2'h1);
		end else if (seq_r == ST_POP_LO && is_handler_r && lvl_r == 2'h2) begin
			irq_hi_prev_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_r <= '{acc: BYTE_ZERO, breg: BYTE_ZERO, sp: SP_RESET, pc: PC_RESET,
				carry: 1'b0, signed_excess_flag: 1'b0};
			seq_r <= ST_IDLE;
			done_r <= 1'b0;
			dwe_r <= 1'b0;
			dwd_r <= BYTE_ZERO;
			bclr_r <= 1'b0;
			swe_r <= 1'b0;
			sad_r <= BYTE_ZERO;
			swd_r <= BYTE_ZERO;
			ack_r <= 1'b0;
			lvl_r <= LVL_IDLE;
			ret_hi_r <= BYTE_ZERO;
			is_handler_r <= 1'b0;
			irq_hi_prev_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			seq_r <= seq_nxt;
			done_r <= done_nxt;
			dwe_r <= dwe_nxt;
			dwd_r <= dwd_nxt;
			bclr_r <= bclr_nxt;
			swe_r <= swe_nxt;
			sad_r <= sad_nxt;
			swd_r <= swd_nxt;
			ack_r <= ack_nxt;
			lvl_r <= lvl_nxt;
			ret_hi_r <= ret_hi_nxt;
			is_handler_r <= is_handler_nxt;
			irq_hi_prev_r <= irq_hi_prev_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign state_o = st_r;
	assign done_o = done_r;
	assign direct_we_o = dwe_r;
	assign direct_wdata_o = dwd_r;
	assign bit_clr_o = bclr_r;
	assign stack_we_o = swe_r;
	assign stack_addr_o = sad_r;
	assign stack_wdata_o = swd_r;
	assign irq_ack_o = ack_r;
	assign irq_level_o = lvl_r;

endmodule : cpu_muldiv_logic_branch_exec

// ---- sim/stack_ram_model.sv ----
`timescale 1ns/100ps
// ----
// Stack RAM on the far side of the block
// ----
module stack_ram_model (
	input wire logic core_clk_i,
	input wire logic we_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [256];
	// Seeded with a pattern, so a stale read never looks like a push
	initial for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'ha5;
	// Write on the clock, read through at once
	always @(posedge core_clk_i) if (we_i) mem[addr_i] <= wdata_i;
	assign rdata_o = mem[addr_i];
endmodule : stack_ram_model

// ---- sim/cpu_exec_asserts.sv ----
`timescale 1ns/100ps
module cpu_exec_asserts (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic instr_valid_i,
	input wire cpu_exec_pkg::instr_s instr_i,
	input wire logic [15:0] next_pc_i,
	input wire logic bit_rd_i,
	input wire logic irq_hi_i,
	input wire cpu_exec_pkg::cpu_state_s state_o,
	input wire logic done_o,
	input wire logic bit_clr_o,
	input wire logic stack_we_o,
	input wire logic [7:0] stack_addr_o,
	input wire logic irq_ack_o,
	input wire logic [1:0] irq_level_o
);
	import cpu_exec_pkg::*;
	instr_s ins_r;
	cpu_state_s st_r;
	logic [15:0] npc_r;
	logic bit_r;
	logic [1:0] lvl_r;
	logic offer_r;
	// Snapshot per offer; valid is only raised while idle
	always_ff @(posedge core_clk_i) begin
		if (instr_valid_i) begin
			ins_r <= instr_i;
			st_r <= state_o;
			npc_r <= next_pc_i;
			bit_r <= bit_rd_i;
			lvl_r <= irq_level_o;
		end
	end
	// Set by an offer, cleared by its done; an interrupt's own done leaves it low
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			offer_r <= 1'b0;
		end else if (instr_valid_i) begin
			offer_r <= 1'b1;
		end else if (done_o) begin
			offer_r <= 1'b0;
		end
	end
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	a_mul_result: assert property (done_o && ins_r.op == OP_PRODUCT |->
		{state_o.breg, state_o.acc} == st_r.acc * st_r.breg
		&& state_o.signed_excess_flag == (st_r.acc * st_r.breg > 16'h00ff)) else $error("product");
	a_div_result: assert property (done_o && ins_r.op == OP_QUOTIENT && st_r.breg != 0 |->
		state_o.acc == st_r.acc / st_r.breg && state_o.breg == st_r.acc % st_r.breg
		&& !state_o.signed_excess_flag) else $error("quotient");
	a_div_zero: assert property (done_o && ins_r.op == OP_QUOTIENT && st_r.breg == 0 |->
		state_o.signed_excess_flag) else $error("zero divisor");
	a_logic_flags: assert property (done_o && ins_r.op inside {OP_AND, OP_OR, OP_XOR} |->
		state_o.signed_excess_flag == st_r.signed_excess_flag
		&& state_o.carry == st_r.carry) else $error("logic flags");
	a_rel_target: assert property (done_o && ins_r.op == OP_REL_JUMP |->
		state_o.pc == npc_r + {{8{ins_r.byte2[7]}}, ins_r.byte2}) else $error("rel target");
	a_clr_taken: assert property (bit_clr_o |->
		ins_r.op == OP_BR_BIT_AND_CLR && bit_r) else $error("bit clear");
	a_push_order: assert property ($rose(stack_we_o) |-> stack_addr_o == state_o.sp + 8'h01
		##1 stack_we_o && stack_addr_o == $past(stack_addr_o) + 8'h01) else $error("push");
	a_sp_step: assert property (!$past(srst_i) && state_o.sp != $past(state_o.sp) |->
		state_o.sp == $past(state_o.sp) + 8'h02 || state_o.sp == $past(state_o.sp) - 8'h02)
		else $error("sp step");
	a_irq_level: assert property (irq_ack_o |->
		$past(irq_level_o) < ($past(irq_hi_i) ? 2'h2 : 2'h1)) else $error("irq level");
	a_exit_level: assert property (offer_r && done_o && ins_r.flow == FL_HANDLER_EXIT |->
		irq_level_o < lvl_r || lvl_r == 2'h0) else $error("exit level");
	c_div_zero: cover property (done_o && ins_r.op == OP_QUOTIENT && st_r.breg == 0);
	c_bit_clr: cover property (bit_clr_o);
	c_irq_high: cover property (irq_ack_o && irq_hi_i);
endmodule : cpu_exec_asserts
bind cpu_muldiv_logic_branch_exec cpu_exec_asserts i_cpu_exec_asserts (.core_clk_i, .srst_i,
	.instr_valid_i, .instr_i, .next_pc_i, .bit_rd_i, .irq_hi_i, .state_o, .done_o, .bit_clr_o,
	.stack_we_o, .stack_addr_o, .irq_ack_o, .irq_level_o);

// ---- sim/tb_cpu_muldiv_logic_branch_exec.sv ----
`timescale 1ns/100ps
module tb_cpu_muldiv_logic_branch_exec;
	import cpu_exec_pkg::*;
	logic core_clk_i = 0;
	logic srst_i = 1;
	logic instr_valid_i = 0;
	instr_s instr_i = '0;
	logic [15:0] next_pc_i = 16'h0000;
	logic [7:0] direct_rd_i = 8'h00;
	logic bit_rd_i = 0;
	logic irq_req_i = 0;
	logic irq_hi_i = 0;
	logic [15:0] irq_vector_i = 16'h0013;
	logic [7:0] stack_rd_i, direct_wdata_o, stack_addr_o, stack_wdata_o, d, a, v, res;
	logic done_o, direct_we_o, bit_clr_o, stack_we_o, irq_ack_o, dst, seen_clr, seen_we;
	logic [1:0] irq_level_o;
	cpu_state_s state_o, m;
	int num_errors = 0;
	int n_checks = 0;
	int n;
	logic [31:0] seed = 41884;
	logic [31:0] r;
	logic [15:0] e;
	logic [7:0] wd_cap;
	exec_op_e o;
	src_sel_e s;
	exec_op_e aop [8] = '{OP_PRODUCT, OP_QUOTIENT, OP_AND, OP_OR, OP_XOR, OP_AND, OP_OR, OP_XOR};
	exec_op_e bop [10] = '{OP_REL_JUMP, OP_BR_ZERO, OP_BR_NONZERO, OP_BR_CARRY, OP_BR_NO_CARRY,
		OP_BR_BIT, OP_BR_BIT_CLEAR, OP_BR_BIT_AND_CLR, OP_LONG_JUMP, OP_BLOCK_JUMP};
	cpu_muldiv_logic_branch_exec i_cpu_muldiv_logic_branch_exec (.core_clk_i, .srst_i,
		.instr_valid_i, .instr_i, .next_pc_i, .direct_rd_i, .bit_rd_i, .stack_rd_i, .irq_req_i,
		.irq_hi_i, .irq_vector_i, .state_o, .done_o, .direct_we_o, .direct_wdata_o, .bit_clr_o,
		.stack_we_o, .stack_addr_o, .stack_wdata_o, .irq_ack_o, .irq_level_o);
	stack_ram_model i_stack_ram_model (.core_clk_i, .we_i(stack_we_o), .addr_i(stack_addr_o),
		.wdata_i(stack_wdata_o), .rdata_o(stack_rd_i));
	// Free-running core clock
	always #5 core_clk_i = ~core_clk_i;
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] lg(input exec_op_e op, input logic [7:0] x, y);
		return op == OP_AND ? x & y : op == OP_OR ? x | y : x ^ y;
	endfunction : lg
	// Carry is never written by this block, so it stays at its reset value
	function automatic logic taken(input exec_op_e op, input logic b);
		case (op)
			OP_BR_ZERO: return m.acc == 8'h00;
			OP_BR_NONZERO: return m.acc != 8'h00;
			OP_BR_CARRY: return m.carry;
			OP_BR_NO_CARRY: return !m.carry;
			OP_BR_BIT, OP_BR_BIT_AND_CLR: return b;
			OP_BR_BIT_CLEAR: return !b;
			default: return 1'b1;
		endcase
	endfunction : taken
	function automatic logic [15:0] stk();
		return {i_stack_ram_model.mem[m.sp], i_stack_ram_model.mem[m.sp - 8'h01]};
	endfunction : stk
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Offer one instruction; operands stay put until done
	task automatic go(input logic [15:0] np);
		next_pc_i = np;
		instr_valid_i = 1;
		@(negedge core_clk_i);
		instr_valid_i = 0;
		seen_clr = 0;
		seen_we = 0;
		// Strobes stand in the done cycle too, so look before leaving
		for (int k = 0; k < 40; k++) begin
			seen_clr |= bit_clr_o === 1'b1;
			if (direct_we_o === 1'b1) begin
				seen_we = 1;
				wd_cap = direct_wdata_o;
			end
			if (done_o === 1'b1)
				break;
			@(negedge core_clk_i);
		end
		chk(done_o === 1'b1, "no done");
	endtask : go
	task automatic irq(input logic hi, input logic want);
		logic got;
		got = 0;
		next_pc_i = {15'h2600, hi};
		irq_hi_i = hi;
		irq_req_i = 1;
		for (int k = 0; k < 12; k++) begin
			@(negedge core_clk_i);
			if (irq_ack_o === 1'b1) begin
				got = 1;
				irq_req_i = 0;
				m.sp = m.sp + 8'h02;
			end
		end
		irq_req_i = 0;
		chk(got === want && state_o.sp === m.sp, "irq accept");
	endtask : irq
	// Watchdog: the sequence needs well under 10k cycles
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (2) @(negedge core_clk_i);
		srst_i = 0;
		m = '{8'h00, 8'h00, SP_RESET, PC_RESET, 1'b0, 1'b0};
		chk(state_o === m, "reset");
		// Random arithmetic and logic; a zero divisor adopts the undefined results
		for (n = 0; n < 300; n++) begin
			r = rnd();
			o = aop[r[2:0]];
			dst = r[2] & r[3];
			s = r[4] ? SRC_IMM : dst ? SRC_ACC : SRC_DIRECT;
			direct_rd_i = r[15:8];
			v = s == SRC_IMM ? r[23:16] : dst ? m.acc : direct_rd_i;
			a = dst ? direct_rd_i : m.acc;
			instr_i = '{o, FL_NONE, s, dst, 8'h00, r[23:16], r[23:16]};
			go(r[31:16]);
			if (o == OP_PRODUCT) begin
				{m.breg, m.acc} = m.acc * m.breg;
				m.signed_excess_flag = |m.breg;
			end else if (o == OP_QUOTIENT) begin
				m.signed_excess_flag = m.breg == 8'h00;
				res = m.signed_excess_flag ? state_o.acc : m.acc / m.breg;
				m.breg = m.signed_excess_flag ? state_o.breg : m.acc % m.breg;
				m.acc = res;
			end else if (dst)
				chk(seen_we === 1'b1 && wd_cap === lg(o, a, v), "direct write");
			else
				m.acc = lg(o, a, v);
			chk(state_o.acc === m.acc && state_o.breg === m.breg, "data");
			chk(state_o.signed_excess_flag === m.signed_excess_flag, "flag");
		end
		// Jumps and branches; first pass uses a zero displacement, later an empty accumulator
		for (n = 0; n < 60; n++) begin
			r = rnd();
			if (n == 30) begin
				instr_i = '{OP_AND, FL_NONE, SRC_IMM, 1'b0, 8'h00, 8'h00, 8'h00};
				go(16'h0000);
				m.acc = 8'h00;
			end
			o = bop[n % 10];
			d = n < 10 ? 8'h00 : r[7:0];
			bit_rd_i = r[8];
			dst = o inside {OP_BR_BIT, OP_BR_BIT_CLEAR, OP_BR_BIT_AND_CLR};
			instr_i = '{o, FL_NONE, SRC_ACC, 1'b0, r[23:16], dst ? r[15:8] : d, dst ? d : r[15:8]};
			go(r[31:16]);
			e = o == OP_LONG_JUMP ? {instr_i.byte2, instr_i.byte3}
				: o == OP_BLOCK_JUMP ? {r[31:16 + BLOCK_LSB], r[16 + OPC_BLK_LSB +: 3], instr_i.byte2}
				: taken(o, r[8]) ? r[31:16] + {{8{d[7]}}, d} : r[31:16];
			chk(state_o.pc === e, "target");
			chk(seen_clr === (o == OP_BR_BIT_AND_CLR && r[8]), "bit clear");
		end
		// Nested calls and returns
		instr_i = '{OP_NONE, FL_LONG_CALL, SRC_ACC, 1'b0, 8'h12, 8'hbe, 8'hef};
		go(16'h1234);
		m.sp = m.sp + 8'h02;
		chk(state_o.pc === 16'hbeef && state_o.sp === m.sp && stk() === 16'h1234, "long_subroutine_call");
		instr_i = '{OP_NONE, FL_BLOCK_CALL, SRC_ACC, 1'b0, 8'he1, 8'h5a, 8'h00};
		go(16'hbef1);
		m.sp = m.sp + 8'h02;
		chk(state_o.pc === 16'hbf5a && stk() === 16'hbef1, "block_subroutine_call");
		instr_i.flow = FL_CALL_EXIT;
		for (n = 0; n < 2; n++) begin
			e = stk();
			go(16'h0000);
			m.sp = m.sp - 8'h02;
			chk(state_o.pc === e && state_o.sp === m.sp, "return");
		end
		chk(e === 16'h1234, "return order");
		// Interrupt nesting by priority
		irq(1'b0, 1'b1);
		chk(state_o.pc === 16'h0013 && irq_level_o === 2'h1, "vector");
		irq(1'b0, 1'b0);
		irq_vector_i = 16'h0023;
		irq(1'b1, 1'b1);
		irq(1'b1, 1'b0);
		instr_i.flow = FL_HANDLER_EXIT;
		for (n = 0; n < 2; n++) begin
			e = stk();
			go(16'h0000);
			m.sp = m.sp - 8'h02;
			chk(state_o.pc === e && e === {15'h2600, !n[0]}, "handler return");
			chk(irq_level_o === 2'(1 - n), "handler exit");
		end
		irq(1'b0, 1'b1);
		end_of_test();
	end
endmodule : tb_cpu_muldiv_logic_branch_exec
